// ---- hw/irq_gate_pkg.sv ----
package irq_gate_pkg;

    // register byte offsets
    localparam logic [7:0] cfg_offset        = 8'h00;
    localparam logic [7:0] serial_a_offset   = 8'h04;
    localparam logic [7:0] serial_b_offset   = 8'h08;
    localparam logic [7:0] par_offset        = 8'h0c;
    localparam logic [7:0] floppy_offset     = 8'h10;
    localparam logic [7:0] event_offset      = 8'h14;
    localparam logic [7:0] mask_offset       = 8'h18;
    localparam logic [7:0] line_offset       = 8'h1c;

    // serial register fields (uart_int_enable_reg low nibble, modem_ctrl bit 3)
    localparam int ier_rx_data_bit   = 0;
    localparam int ier_thre_bit      = 1;
    localparam int ier_rx_err_bit    = 2;
    localparam int ier_modem_bit     = 3;
    localparam int mcr_out_en_bit    = 3;
    localparam int ser_mcr_lsb       = 8;
    localparam int ser_com_lsb       = 16;

    // par_port_cfg_reg / control fields
    localparam int par_ctrl_irq_en_bit = 4;
    localparam int par_cfg_bidir_bit   = 6;
    localparam int par_cfg_lsb         = 8;
    localparam int par_ecp_bit         = 16;
    localparam int par_addr_ok_bit     = 17;
    localparam int par_line_sel_bit    = 18;

    // floppy_digital_output_reg bit 3 gates the request, except in fdc_mode_alt where it always passes
    localparam int dor_irq_gate_bit  = 3;

    // config fields
    localparam int cfg_fdc_mode_lsb  = 0;
    localparam int cfg_aux_lsb       = 8;
    localparam int aux_sixteen_bit_select_in_off_bit  = 2;

    // event status bits
    localparam int ev_ser_a     = 0;
    localparam int ev_ser_b     = 1;
    localparam int ev_par       = 2;
    localparam int ev_fdc       = 3;
    localparam int ev_width     = 4;

    localparam logic [31:0] rd_zero = 32'h0000_0000;

    typedef enum logic [1:0] {
        com_1 = 2'b00,
        com_2 = 2'b01,
        com_3 = 2'b10,
        com_4 = 2'b11
    } com_desig_t;

    typedef enum logic [1:0] {
        fdc_mode_at     = 2'b00,
        fdc_mode_m30    = 2'b01,
        fdc_mode_alt    = 2'b10,
        fdc_mode_rsvd   = 2'b11
    } fdc_mode_t;

    typedef struct packed {
        logic rx_err;
        logic rx_data;
        logic thre;
        logic modem;
    } ser_cause_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

endpackage

// ---- hw/serial_irq_qual.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_irq_qual
    import irq_gate_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire ser_cause_t cause,
    input  wire logic [3:0] int_enable,
    input  wire logic       out_enable,
    output logic            req_ff,
    output logic            drive_ff
);
    logic nxt_req;

    always_comb begin
        nxt_req = out_enable & ((cause.rx_err  & int_enable[ier_rx_err_bit])
                              | (cause.rx_data & int_enable[ier_rx_data_bit])
                              | (cause.thre    & int_enable[ier_thre_bit])
                              | (cause.modem   & int_enable[ier_modem_bit]));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= out_enable;
        end
    end
endmodule
`default_nettype wire

// ---- hw/peripheral_irq_output_gating.sv ----
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_output_gating
    import irq_gate_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire ser_cause_t  ser_a_cause,
    input  wire ser_cause_t  ser_b_cause,
    input  wire logic        printer_ack_in,
    input  wire logic        par_irq_in,
    input  wire logic        fdc_exec_done,
    input  wire logic        fdc_byte_ready,
    input  wire logic        sixteen_bit_select_in,
    output logic             irq_lo_ser_o,
    output logic             irq_lo_ser_oe,
    output logic             irq_hi_ser_o,
    output logic             irq_hi_ser_oe,
    output logic             irq_par_o,
    output logic             irq_par_oe,
    output logic             irq_par_bidir,
    output logic             irq_fdc_o,
    output logic             irq_fdc_oe,
    output logic             sixteen_bit_sel_o,
    output logic             irq_o
);
    // per channel: [3:0] uart_int_enable_reg, [11:8] modem ctrl, [17:16] com
    logic [31:0] ser_reg_ff [2];
    // [7:0] parallel control, [15:8] par_port_cfg_reg, ecp, addr ok, line sel
    logic [18:0] par_reg_ff;
    logic [7:0]  floppy_digital_output_reg;
    logic [1:0]  fdc_mode_ff;
    logic [7:0]  aux_select_cfg_reg;
    logic [ev_width-1:0] status_ff;
    logic [ev_width-1:0] mask_ff;

    logic        bus_req;
    logic        wr_stb;
    logic        rd_stb;
    logic        wr_cfg;
    logic        wr_par;
    logic        wr_floppy;
    logic        wr_event;
    logic        wr_mask;
    logic [31:0] wmask;
    logic [31:0] nxt_rdata;

    // writable serial fields: enables, modem ctrl, designation
    localparam logic [31:0] ser_wr_mask = 32'h0003_0f0f;

    logic [1:0]  ser_req;
    logic [1:0]  ser_drv;
    logic [1:0]  lo_hit;
    logic [1:0]  hi_hit;
    com_desig_t  ser_com [2];

    // three-stage input samplers: ack, par pin, fdc events, 16-bit select
    localparam int n_sync     = 5;
    localparam int sync_ack   = 0;
    localparam int sync_par   = 1;
    localparam int sync_done  = 2;
    localparam int sync_byte  = 3;
    localparam int sync_sel16 = 4;
    logic [n_sync-1:0] sync_raw;
    logic [n_sync-1:0] s1_ff;
    logic [n_sync-1:0] s2_ff;
    logic [n_sync-1:0] s3_ff;
    logic [n_sync-1:0] clean_ff;

    logic par_enabled;
    logic fdc_gate;
    logic fdc_evt;
    logic [ev_width-1:0] ev_now;
    pin_drive_t          nxt_lo_ser;
    pin_drive_t          nxt_hi_ser;
    pin_drive_t          nxt_par;
    pin_drive_t          nxt_fdc;

    // field positions must fit the registers that hold them
    if (ser_com_lsb + 2 > 32 || par_line_sel_bit > 18 || par_cfg_lsb + par_cfg_bidir_bit > 15
        || ev_width != 4 || n_sync != 5) begin : g_layout_check
        $error("register field layout does not fit its storage");
    end

    assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_stb    = bus_req & wb_we_i;
    assign rd_stb    = bus_req & ~wb_we_i;
    assign wr_cfg    = wr_stb && wb_adr_i == cfg_offset;
    assign wr_par    = wr_stb && wb_adr_i == par_offset;
    assign wr_floppy = wr_stb && wb_adr_i == floppy_offset;
    assign wr_event  = wr_stb && wb_adr_i == event_offset;
    assign wr_mask   = wr_stb && wb_adr_i == mask_offset;
    assign wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // one-cycle ack per request
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_comb begin
        unique case (wb_adr_i)
            cfg_offset:      nxt_rdata = {16'h0000, aux_select_cfg_reg, 6'h00, fdc_mode_ff};
            serial_a_offset: nxt_rdata = ser_reg_ff[0];
            serial_b_offset: nxt_rdata = ser_reg_ff[1];
            par_offset:      nxt_rdata = {13'h0000, par_reg_ff};
            floppy_offset:   nxt_rdata = {24'h000000, floppy_digital_output_reg};
            event_offset:    nxt_rdata = {28'h0000000, status_ff};
            mask_offset:     nxt_rdata = {28'h0000000, mask_ff};
            line_offset:     nxt_rdata = {18'h0_0000, clean_ff, irq_o, irq_fdc_o, irq_par_o,
                                          irq_par_oe, irq_hi_ser_o, irq_hi_ser_oe,
                                          irq_lo_ser_o, irq_lo_ser_oe, irq_par_bidir};
            default:         nxt_rdata = rd_zero;
        endcase
    end

    // read data captured with the ack
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_dat_o <= rd_zero;
        end else if (rd_stb) begin
            wb_dat_o <= nxt_rdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ser
            always_ff @(posedge clk) begin
                if (reset) begin
                    ser_reg_ff[gi] <= rd_zero;
                end else if (wr_stb && wb_adr_i == (gi == 0 ? serial_a_offset
                                                            : serial_b_offset)) begin
                    ser_reg_ff[gi] <= (ser_reg_ff[gi] & ~wmask)
                                    | (wb_dat_i & wmask & ser_wr_mask);
                end
            end

            serial_irq_qual u_qual (
                .clk        (clk),
                .reset      (reset),
                .cause      (gi == 0 ? ser_a_cause : ser_b_cause),
                .int_enable (ser_reg_ff[gi][3:0]),
                .out_enable (ser_reg_ff[gi][ser_mcr_lsb + mcr_out_en_bit]),
                .req_ff     (ser_req[gi]),
                .drive_ff   (ser_drv[gi])
            );

            assign ser_com[gi] = com_desig_t'(ser_reg_ff[gi][ser_com_lsb +: 2]);
            assign lo_hit[gi]  = ser_com[gi] == com_2 || ser_com[gi] == com_4;
            assign hi_hit[gi]  = !lo_hit[gi];
        end
    endgenerate

    // byte-lane writes to the parallel register
    always_ff @(posedge clk) begin
        if (reset) begin
            par_reg_ff <= 19'h00000;
        end else if (wr_par) begin
            par_reg_ff <= (par_reg_ff & ~wmask[18:0]) | (wb_dat_i[18:0] & wmask[18:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            floppy_digital_output_reg <= 8'h00;
        end else if (wr_floppy && wb_sel_i[0]) begin
            floppy_digital_output_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fdc_mode_ff        <= fdc_mode_at;
            aux_select_cfg_reg <= 8'h00;
        end else if (wr_cfg) begin
            if (wb_sel_i[0]) begin
                fdc_mode_ff <= wb_dat_i[cfg_fdc_mode_lsb +: 2];
            end
            if (wb_sel_i[1]) begin
                aux_select_cfg_reg <= wb_dat_i[cfg_aux_lsb +: 8];
            end
        end
    end

    assign sync_raw = {sixteen_bit_select_in, fdc_byte_ready, fdc_exec_done,
                       par_irq_in, printer_ack_in};

    // three-flop chain per asynchronous input
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= sync_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a level counts once the last two stages agree
    always_ff @(posedge clk) begin
        if (reset) begin
            clean_ff <= '0;
        end else begin
            clean_ff <= (s2_ff & s3_ff) | (clean_ff & (s2_ff | s3_ff));
        end
    end

    // next pin values, gathered per request line
    always_comb begin
        nxt_lo_ser.out = |(ser_req & lo_hit);
        nxt_lo_ser.oe  = |(ser_drv & lo_hit);
        nxt_hi_ser.out = |(ser_req & hi_hit);
        nxt_hi_ser.oe  = |(ser_drv & hi_hit);
        nxt_par.out    = par_enabled & clean_ff[sync_ack];
        nxt_par.oe     = par_enabled;
        nxt_fdc.out    = fdc_gate & fdc_evt;
        nxt_fdc.oe     = fdc_gate;
    end

    // serial lines, active high, merged per line
    // active-high serial drive
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_lo_ser_o  <= 1'b0;
            irq_lo_ser_oe <= 1'b0;
            irq_hi_ser_o  <= 1'b0;
            irq_hi_ser_oe <= 1'b0;
        end else begin
            irq_lo_ser_o  <= nxt_lo_ser.out;
            irq_lo_ser_oe <= nxt_lo_ser.oe;
            irq_hi_ser_o  <= nxt_hi_ser.out;
            irq_hi_ser_oe <= nxt_hi_ser.oe;
        end
    end

    assign par_enabled = par_reg_ff[par_ctrl_irq_en_bit] & par_reg_ff[par_addr_ok_bit];

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_par_o     <= 1'b0;
            irq_par_oe    <= 1'b0;
            irq_par_bidir <= 1'b0;
        end else begin
            irq_par_o     <= nxt_par.out;
            irq_par_oe    <= nxt_par.oe;
            irq_par_bidir <= par_reg_ff[par_ecp_bit] & par_reg_ff[par_line_sel_bit]
                           & par_reg_ff[par_cfg_lsb + par_cfg_bidir_bit];
        end
    end

    assign fdc_gate = (fdc_mode_ff == fdc_mode_alt)
                    | floppy_digital_output_reg[dor_irq_gate_bit];
    assign fdc_evt = clean_ff[sync_done] | clean_ff[sync_byte];

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_fdc_o  <= 1'b0;
            irq_fdc_oe <= 1'b0;
        end else begin
            irq_fdc_o  <= nxt_fdc.out;
            irq_fdc_oe <= nxt_fdc.oe;
        end
    end

    // select used while aux bit2 zero
    always_ff @(posedge clk) begin
        if (reset) begin
            sixteen_bit_sel_o <= 1'b0;
        end else begin
            sixteen_bit_sel_o <= ~aux_select_cfg_reg[aux_sixteen_bit_select_in_off_bit] & clean_ff[sync_sel16];
        end
    end

    // sticky events, set wins over write-one clear
    assign ev_now = {irq_fdc_o, irq_par_o, nxt_hi_ser.out, nxt_lo_ser.out};

    always_ff @(posedge clk) begin
        if (reset) begin
            status_ff <= '0;
        end else if (wr_event && wb_sel_i[0]) begin
            status_ff <= (status_ff & ~wb_dat_i[ev_width-1:0]) | ev_now;
        end else begin
            status_ff <= status_ff | ev_now;
        end
    end

    // mask of the status bits
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_ff <= '0;
        end else if (wr_mask && wb_sel_i[0]) begin
            mask_ff <= wb_dat_i[ev_width-1:0];
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_ff & mask_ff);
        end
    end
endmodule
`default_nettype wire

// ---- dv/irq_gate_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module irq_gate_checker
    import irq_gate_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire ser_cause_t  ser_a_cause,
    input wire ser_cause_t  ser_b_cause,
    input wire logic        printer_ack_in,
    input wire logic        fdc_exec_done,
    input wire logic        fdc_byte_ready,
    input wire logic        irq_lo_ser_o,
    input wire logic        irq_hi_ser_o,
    input wire logic        irq_par_o,
    input wire logic        irq_fdc_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_rdata_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data changed without read");
    a_ser_quiet: assert property ((ser_a_cause == '0 && ser_b_cause == '0) [*3]
        |=> !irq_lo_ser_o && !irq_hi_ser_o) else $error("serial request without cause");
    a_ser_rise_cause: assert property ($rose(irq_lo_ser_o || irq_hi_ser_o)
        |-> $past(ser_a_cause != '0 || ser_b_cause != '0, 2)) else $error("serial rise");
    a_par_quiet: assert property (!printer_ack_in [*8] |=> !irq_par_o)
        else $error("parallel request without acknowledge");
    a_fdc_quiet: assert property (!(fdc_exec_done || fdc_byte_ready) [*8] |=> !irq_fdc_o)
        else $error("floppy request without event");
    cover property (irq_hi_ser_o);
    cover property (irq_lo_ser_o);
    cover property (irq_par_o);
    cover property (irq_fdc_o);
endmodule
bind peripheral_irq_output_gating irq_gate_checker chk (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ser_a_cause(ser_a_cause),
    .ser_b_cause(ser_b_cause), .printer_ack_in(printer_ack_in),
    .fdc_exec_done(fdc_exec_done), .fdc_byte_ready(fdc_byte_ready),
    .irq_lo_ser_o(irq_lo_ser_o), .irq_hi_ser_o(irq_hi_ser_o), .irq_par_o(irq_par_o),
    .irq_fdc_o(irq_fdc_o));
`default_nettype wire

// ---- dv/irq_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module irq_host_model (
    input  wire logic       clk,
    input  wire logic [3:0] line_o,
    input  wire logic [3:0] line_oe,
    output logic      [3:0] lvl
);
    logic [3:0] last_ff = 4'h0;
    assign lvl = (line_oe & line_o) | (~line_oe & ~last_ff);
    always_ff @(posedge clk) begin
        last_ff <= lvl;
    end
endmodule
`default_nettype wire

// ---- dv/tb_peripheral_irq_output_gating.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_peripheral_irq_output_gating
    import irq_gate_pkg::*;
();
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        req = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rdat;
    logic        wb_ack_o, irq_lo_ser_o, irq_lo_ser_oe, irq_hi_ser_o, irq_hi_ser_oe;
    logic        irq_par_o, irq_par_oe, irq_par_bidir, irq_fdc_o, irq_fdc_oe;
    logic        sixteen_bit_sel_o, irq_o;
    ser_cause_t  ser_a_cause = '0;
    ser_cause_t  ser_b_cause = '0;
    logic        printer_ack_in = 1'b0;
    logic        fdc_exec_done = 1'b0;
    logic        fdc_byte_ready = 1'b0;
    logic        sixteen_bit_select_in = 1'b0;
    logic [3:0]  lvl;
    int          miscompares = 0;
    int          tests_run = 0;

    always #10 clk = ~clk;

    peripheral_irq_output_gating DUT (
        .clk(clk), .reset(reset), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ser_a_cause(ser_a_cause), .ser_b_cause(ser_b_cause),
        .printer_ack_in(printer_ack_in), .par_irq_in(1'b0), .fdc_exec_done(fdc_exec_done),
        .fdc_byte_ready(fdc_byte_ready), .sixteen_bit_select_in(sixteen_bit_select_in),
        .irq_lo_ser_o(irq_lo_ser_o), .irq_lo_ser_oe(irq_lo_ser_oe),
        .irq_hi_ser_o(irq_hi_ser_o), .irq_hi_ser_oe(irq_hi_ser_oe), .irq_par_o(irq_par_o),
        .irq_par_oe(irq_par_oe), .irq_par_bidir(irq_par_bidir), .irq_fdc_o(irq_fdc_o),
        .irq_fdc_oe(irq_fdc_oe), .sixteen_bit_sel_o(sixteen_bit_sel_o), .irq_o(irq_o));
    irq_host_model host (.clk(clk), .lvl(lvl),
        .line_o({irq_fdc_o, irq_par_o, irq_hi_ser_o, irq_lo_ser_o}),
        .line_oe({irq_fdc_oe, irq_par_oe, irq_hi_ser_oe, irq_lo_ser_oe}));

    task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        req      <= 1'b1;
        wb_adr_i <= a;
        wb_we_i  <= wr;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        req <= 1'b0;
    endtask

    task automatic w(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        acc(cfg_offset, 1'b0, 32'h0);
        ck(rdat, rd_zero);
        acc(8'h20, 1'b1, 32'hffff_ffff);
        acc(8'h20, 1'b0, 32'h0);
        ck(rdat, rd_zero);
        for (int c = 0; c < 4; c++) begin
            acc(serial_a_offset, 1'b1, 32'h0000_080f | (c << ser_com_lsb));
            @(posedge clk) ser_a_cause <= ser_cause_t'(4'h8 >> c);
            w(4);
            ck({irq_lo_ser_o, lvl[c[0] ? 0 : 1]}, {c[0], 1'b1});
            ck(irq_hi_ser_o, !c[0]);
            @(posedge clk) ser_a_cause <= '0;
            w(4);
            ck({irq_hi_ser_o, irq_lo_ser_o}, 2'b00);
        end
        acc(serial_a_offset, 1'b1, 32'h0);
        acc(serial_b_offset, 1'b1, 32'h0001_0801);
        @(posedge clk) ser_b_cause <= 4'h2;
        w(4);
        ck(irq_lo_ser_o, 1'b0);
        @(posedge clk) ser_b_cause <= 4'h4;
        w(4);
        ck({irq_lo_ser_o, irq_lo_ser_oe}, 2'b11);
        acc(serial_b_offset, 1'b1, 32'h0001_0001);
        w(4);
        ck({irq_lo_ser_o, irq_lo_ser_oe}, 2'b00);
        @(posedge clk) ser_b_cause <= '0;
        acc(par_offset, 1'b1, 32'h0002_0010);
        @(posedge clk) printer_ack_in <= 1'b1;
        w(8);
        ck({irq_par_o, irq_par_oe, lvl[2]}, 3'b111);
        @(posedge clk) printer_ack_in <= 1'b0;
        w(8);
        ck({irq_par_o, irq_par_oe}, 2'b01);
        acc(par_offset, 1'b1, 32'h0000_0010);
        w(3);
        ck(irq_par_oe, 1'b0);
        acc(par_offset, 1'b1, 32'h0007_4010);
        w(3);
        ck(irq_par_bidir, 1'b1);
        acc(par_offset, 1'b1, 32'h0003_4010);
        w(3);
        ck(irq_par_bidir, 1'b0);
        acc(floppy_offset, 1'b1, 32'h0);
        w(3);
        ck(irq_fdc_oe, 1'b0);
        acc(floppy_offset, 1'b1, 32'h8);
        acc(event_offset, 1'b1, 32'hf);
        acc(mask_offset, 1'b1, 32'h8);
        @(posedge clk) fdc_exec_done <= 1'b1;
        w(10);
        ck({irq_fdc_o, irq_fdc_oe, irq_o}, 3'b111);
        acc(event_offset, 1'b0, 32'h0);
        ck(rdat, 32'h8);
        acc(mask_offset, 1'b1, 32'h0);
        w(3);
        ck(irq_o, 1'b0);
        @(posedge clk) fdc_exec_done <= 1'b0;
        w(8);
        acc(event_offset, 1'b1, 32'h8);
        acc(event_offset, 1'b0, 32'h0);
        ck({irq_fdc_o, rdat[3:0]}, 5'h00);
        @(posedge clk) fdc_byte_ready <= 1'b1;
        w(8);
        ck(irq_fdc_o, 1'b1);
        @(posedge clk) fdc_byte_ready <= 1'b0;
        acc(floppy_offset, 1'b1, 32'h0);
        acc(cfg_offset, 1'b1, 32'h2);
        w(3);
        ck(irq_fdc_oe, 1'b1);
        acc(cfg_offset, 1'b1, 32'h0);
        @(posedge clk) sixteen_bit_select_in <= 1'b1;
        w(8);
        ck(sixteen_bit_sel_o, 1'b1);
        @(posedge clk) sixteen_bit_select_in <= 1'b0;
        w(8);
        ck(sixteen_bit_sel_o, 1'b0);
        acc(cfg_offset, 1'b1, 32'h0000_0400);
        @(posedge clk) sixteen_bit_select_in <= 1'b1;
        w(8);
        ck(sixteen_bit_sel_o, 1'b0);
        results();
    end
endmodule
`default_nettype wire
